// *** rtl/scd_serial_regs.sv ***
// Data, divider, trigger and status registers of two serial channels
`timescale 1ns/100ps

module scd_serial_regs
#(
	parameter int NCH   = scd_pkg::NUM_CHANNELS,
	parameter int DIV_W = scd_pkg::DIV_WIDTH
)
(
	// Clock and reset
	input  wire logic                 i_core_clk,
	input  wire logic                 i_rst,
	// CPU register port
	input  scd_pkg::scd_cpu_req_t     i_cpu,
	output logic [7:0]                o_cpu_rdata,
	// Channel control and shift register events
	input  scd_pkg::scd_chan_ctrl_t   i_ctrl [NCH],
	input  scd_pkg::scd_shift_evt_t   i_evt  [NCH],
	input  wire logic [NCH-1:0]       i_serial_clock_pin,
	// Towards the shift registers
	output logic [NCH-1:0]            o_xfer_tick,
	output logic [NCH-1:0]            o_tx_valid,
	output logic [7:0]                o_tx_data [NCH],
	output logic [NCH-1:0]            o_busy
);

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	localparam logic [19:0] A_STAT [2] =
		'{scd_pkg::ADDR_STATUS_CH0, scd_pkg::ADDR_STATUS_CH1};
	localparam logic [19:0] A_TRIG [2] =
		'{scd_pkg::ADDR_TRIGGER_CH0, scd_pkg::ADDR_TRIGGER_CH1};
	localparam logic [19:0] A_DATA [2] =
		'{scd_pkg::ADDR_DATA_CH0, scd_pkg::ADDR_DATA_CH1};
	localparam logic [19:0] A_DIV  [2] =
		'{scd_pkg::ADDR_DIVIDER_CH0, scd_pkg::ADDR_DIVIDER_CH1};

	logic [7:0] rd_word [NCH];
	logic [7:0] status  [NCH];

	genvar ch;
	generate
		for (ch = 0; ch < NCH; ch++)
		begin : g_ch
			logic [7:0]       divider_q;
			logic [7:0]       data_q;
			logic [2:0]       trigger_q;
			logic             framing_q;
			logic             parity_q;
			logic             overrun_q;
			logic             full_q;
			logic             busy_q;
			logic             wr_div;
			logic             wr_data;
			logic             wr_trig;
			logic             rd_data;
			logic             rd_stat;
			logic             rd_div;
			logic             enabled;
			logic             stop_start;
			logic             rx_error;
			logic [2:0]       trig_bits;
			logic             set_full;
			logic             clr_full;
			logic             set_busy;
			logic             clr_busy;
			logic             set_fe;
			logic             set_pe;
			logic             set_ov;

			// ----------------------------------------------------
			// Channel control and address strobes
			// ----------------------------------------------------
			assign enabled    = i_ctrl[ch].operation_enable;
			assign stop_start = i_ctrl[ch].stop_trigger
				|| i_ctrl[ch].start_trigger;
			assign wr_div  = i_cpu.wr && (i_cpu.addr == A_DIV[ch]);
			assign wr_data = i_cpu.wr && (i_cpu.addr == A_DATA[ch]);
			assign wr_trig = i_cpu.wr && (i_cpu.addr == A_TRIG[ch]);
			assign rd_data = i_cpu.rd && (i_cpu.addr == A_DATA[ch]);
			assign rd_stat = i_cpu.rd && (i_cpu.addr == A_STAT[ch]);
			assign rd_div  = i_cpu.rd && (i_cpu.addr == A_DIV[ch]);

			// ----------------------------------------------------
			// Receive errors and trigger bits
			// ----------------------------------------------------
			// missing stop bit (framing channels only) or parity mismatch
			assign rx_error = (i_evt[ch].rx_no_stop
				&& scd_pkg::HAS_FRAMING[ch])
				|| i_evt[ch].rx_parity_bad;

			// Unused trigger bits are dropped, so stray ones do nothing
			assign trig_bits = {i_cpu.wdata[scd_pkg::BIT_FRAMING]
				&& scd_pkg::HAS_FRAMING[ch],
				i_cpu.wdata[scd_pkg::BIT_PARITY],
				i_cpu.wdata[scd_pkg::BIT_OVERRUN]};

			// ----------------------------------------------------
			// Divider register
			// ----------------------------------------------------
			// writes blocked while enabled
			always_ff @(posedge i_core_clk or posedge i_rst)
			begin
				if (i_rst)
					divider_q <= scd_pkg::RESET_VALUE;
				else if (wr_div && !enabled)
					divider_q <= i_cpu.wdata;
			end

			scd_clk_div
			#(
				.DIV_W (DIV_W)
			)
			u_div
			(
				.i_core_clk         (i_core_clk),
				.i_rst              (i_rst),
				.i_run              (enabled),
				.i_ext_sel          (i_ctrl[ch].external_clock_select),
				.i_divisor          (divider_q[scd_pkg::DIV_LSB +: DIV_W]),
				.i_serial_clock_pin (i_serial_clock_pin[ch]),
				.o_xfer_tick        (o_xfer_tick[ch])
			);

			// ----------------------------------------------------
			// Data buffer
			// ----------------------------------------------------
			// buffer between CPU and shifter
			always_ff @(posedge i_core_clk or posedge i_rst)
			begin
				if (i_rst)
					data_q <= scd_pkg::RESET_VALUE;
				else if (wr_data && enabled)
					data_q <= i_cpu.wdata;
				else if (i_evt[ch].rx_store && i_ctrl[ch].receive_enable)
					data_q <= i_evt[ch].rx_data;
			end

			assign o_tx_data[ch]  = data_q;
			assign o_tx_valid[ch] = full_q && i_ctrl[ch].transmit_enable;

			// ----------------------------------------------------
			// Buffer-full flag
			// ----------------------------------------------------
			// set events win over clears
			assign set_full = (wr_data && enabled
				&& i_ctrl[ch].transmit_enable)
				|| (i_evt[ch].rx_store && i_ctrl[ch].receive_enable)
				|| rx_error;
			assign clr_full = i_evt[ch].tx_taken || rd_data
				|| stop_start;

			always_ff @(posedge i_core_clk or posedge i_rst)
			begin
				if (i_rst)
					full_q <= 1'b0;
				else if (set_full)
					full_q <= 1'b1;
				else if (clr_full)
					full_q <= 1'b0;
			end

			// ----------------------------------------------------
			// Busy flag
			// ----------------------------------------------------
			// set on start, clear on stop/suspend/end
			assign set_busy = i_evt[ch].comm_start;
			assign clr_busy = i_ctrl[ch].stop_trigger || i_evt[ch].suspend
				|| i_evt[ch].comm_end;

			// Start wins, so a back-to-back frame keeps the flag up
			always_ff @(posedge i_core_clk or posedge i_rst)
			begin
				if (i_rst)
					busy_q <= 1'b0;
				else if (set_busy)
					busy_q <= 1'b1;
				else if (clr_busy)
					busy_q <= 1'b0;
			end

			assign o_busy[ch] = busy_q;

			// ----------------------------------------------------
			// Framing error flag
			// ----------------------------------------------------
			// missing stop bit, channel 1 only
			assign set_fe = i_evt[ch].rx_no_stop
				&& scd_pkg::HAS_FRAMING[ch];

			always_ff @(posedge i_core_clk or posedge i_rst)
			begin
				if (i_rst)
					framing_q <= 1'b0;
				else if (set_fe)
					framing_q <= 1'b1;
				else if (trigger_q[2])
					framing_q <= 1'b0;
			end

			// ----------------------------------------------------
			// Parity error flag
			// ----------------------------------------------------
			// parity mismatch
			assign set_pe = i_evt[ch].rx_parity_bad;

			always_ff @(posedge i_core_clk or posedge i_rst)
			begin
				if (i_rst)
					parity_q <= 1'b0;
				else if (set_pe)
					parity_q <= 1'b1;
				else if (trigger_q[1])
					parity_q <= 1'b0;
			end

			// ----------------------------------------------------
			// Overrun error flag
			// ----------------------------------------------------
			// write while full; a store while full sets it too, and overwrites the buffer only while receive_enable is set and no CPU write wins
			assign set_ov = full_q && ((wr_data && enabled)
				|| i_evt[ch].rx_store);

			always_ff @(posedge i_core_clk or posedge i_rst)
			begin
				if (i_rst)
					overrun_q <= 1'b0;
				else if (set_ov)
					overrun_q <= 1'b1;
				else if (trigger_q[0])
					overrun_q <= 1'b0;
			end

			// ----------------------------------------------------
			// Flag clear trigger
			// ----------------------------------------------------
			// self-clears after one cycle
			always_ff @(posedge i_core_clk or posedge i_rst)
			begin
				if (i_rst)
					trigger_q <= '0;
				else if (wr_trig)
					trigger_q <= trig_bits;
				else
					trigger_q <= '0;
			end

			// ----------------------------------------------------
			// Status word
			// ----------------------------------------------------
			// status layout
			always_comb
			begin
				status[ch] = 8'h00;
				status[ch][scd_pkg::BIT_IN_PROGRESS] = busy_q;
				status[ch][scd_pkg::BIT_BUFFER_FULL] = full_q;
				status[ch][scd_pkg::BIT_FRAMING]     = framing_q;
				status[ch][scd_pkg::BIT_PARITY]      = parity_q;
				status[ch][scd_pkg::BIT_OVERRUN]     = overrun_q;
			end

			// ----------------------------------------------------
			// Read select
			// ----------------------------------------------------
			// divider reads zero while enabled
			always_comb
			begin
				rd_word[ch] = 8'h00;
				if (rd_stat)
					rd_word[ch] = status[ch];
				else if (rd_data)
					rd_word[ch] = data_q;
				else if (rd_div && !enabled)
					rd_word[ch] = divider_q;
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Read data, registered one cycle after the strobe
	// ------------------------------------------------------------
	logic [7:0] rdata_q;

	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
			rdata_q <= 8'h00;
		else if (i_cpu.rd)
			rdata_q <= rd_word[0] | rd_word[1];
	end

	assign o_cpu_rdata = rdata_q;

endmodule

// *** rtl/scd_pkg.sv ***
// Package: register map, field positions and types of the serial channels
package scd_pkg;

	// ------------------------------------------------------------
	// Register addresses (byte addresses on the 20-bit CPU bus)
	// ------------------------------------------------------------
	localparam logic [19:0] ADDR_STATUS_CH0   = 20'hf0100;
	localparam logic [19:0] ADDR_STATUS_CH1   = 20'hf0102;
	localparam logic [19:0] ADDR_TRIGGER_CH0  = 20'hf0108;
	localparam logic [19:0] ADDR_TRIGGER_CH1  = 20'hf010a;
	localparam logic [19:0] ADDR_DATA_CH0     = 20'hfff10;
	localparam logic [19:0] ADDR_DIVIDER_CH0  = 20'hfff11;
	localparam logic [19:0] ADDR_DATA_CH1     = 20'hfff12;
	localparam logic [19:0] ADDR_DIVIDER_CH1  = 20'hfff13;

	// ------------------------------------------------------------
	// Reset values and field positions
	// ------------------------------------------------------------
	localparam logic [7:0] RESET_VALUE        = 8'h00;
	localparam int         BIT_OVERRUN        = 0;
	localparam int         BIT_PARITY         = 1;
	localparam int         BIT_FRAMING        = 2;
	localparam int         BIT_BUFFER_FULL    = 5;
	localparam int         BIT_IN_PROGRESS    = 6;
	localparam int         DIV_LSB            = 1;
	localparam int         DIV_WIDTH          = 7;
	localparam int         NUM_CHANNELS       = 2;
	// Only channel 1 has a framing error flag
	localparam logic [NUM_CHANNELS-1:0] HAS_FRAMING = 2'h2;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		CLK_IDLE     = 2'b00,
		CLK_INTERNAL = 2'b01,
		CLK_EXTERNAL = 2'b10
	} scd_clk_src_t;

	// CPU register access
	typedef struct packed
	{
		logic        rd;
		logic        wr;
		logic [19:0] addr;
		logic [7:0]  wdata;
	} scd_cpu_req_t;

	// Per-channel control from start/stop and mode logic
	typedef struct packed
	{
		logic operation_enable;
		logic stop_trigger;
		logic start_trigger;
		logic external_clock_select;
		logic transmit_enable;
		logic receive_enable;
	} scd_chan_ctrl_t;

	// Per-channel events from the shift register
	typedef struct packed
	{
		logic       comm_start;
		logic       comm_end;
		logic       suspend;
		logic       tx_taken;
		logic       rx_store;
		logic [7:0] rx_data;
		logic       rx_no_stop;
		logic       rx_parity_bad;
	} scd_shift_evt_t;

endpackage

// *** rtl/scd_clk_div.sv ***
// Transfer clock divider: one-cycle enable at f/(2*(N+1)), or on each pin rising edge when external clock is selected
`timescale 1ns/100ps

module scd_clk_div
#(
	parameter int DIV_W = 7
)
(
	// Clock and reset
	input  wire logic             i_core_clk,
	input  wire logic             i_rst,
	// Control
	input  wire logic             i_run,
	input  wire logic             i_ext_sel,
	input  wire logic [DIV_W-1:0] i_divisor,
	input  wire logic             i_serial_clock_pin,
	// Transfer clock enable
	output logic                  o_xfer_tick
);

	logic [DIV_W:0] count_q;
	logic           pin_q;
	logic           int_tick;
	logic           ext_tick;
	logic [DIV_W:0] last_count;

	// Counter runs 0 to 2N+1, so one tick every 2*(N+1) cycles
	assign last_count = {i_divisor, 1'b1};

	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
			count_q <= '0;
		else if (!i_run || i_ext_sel || int_tick)
			count_q <= '0;
		else
			count_q <= count_q + 1'b1;
	end

	assign int_tick = i_run && !i_ext_sel && (count_q == last_count);

	// Pin is synchronous; rising edge marks an external transfer clock
	always_ff @(posedge i_core_clk or posedge i_rst)
	begin
		if (i_rst)
			pin_q <= 1'b0;
		else
			pin_q <= i_serial_clock_pin;
	end

	assign ext_tick = i_run && i_ext_sel && i_serial_clock_pin && !pin_q;

	assign o_xfer_tick = int_tick || ext_tick;

endmodule

// *** verification/scd_serial_regs_monitor.sv ***
// Checker: port-level timing relations of the serial channel registers
`timescale 1ns/100ps

module scd_regs_chk
#(
	parameter int NCH = 2
)
(
	// Clock and reset
	input wire logic                  i_core_clk,
	input wire logic                  i_rst,
	// Observed ports
	input scd_pkg::scd_cpu_req_t      i_cpu,
	input wire logic [7:0]            o_cpu_rdata,
	input scd_pkg::scd_chan_ctrl_t    i_ctrl [NCH],
	input scd_pkg::scd_shift_evt_t    i_evt  [NCH],
	input wire logic [NCH-1:0]        i_serial_clock_pin,
	input wire logic [NCH-1:0]        o_xfer_tick,
	input wire logic [NCH-1:0]        o_tx_valid,
	input wire logic [7:0]            o_tx_data [NCH],
	input wire logic [NCH-1:0]        o_busy
);
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	sequence s_rd(a);
		i_cpu.rd && i_cpu.addr == a;
	endsequence
	sequence s_wr_data0;
		i_cpu.wr && i_cpu.addr == scd_pkg::ADDR_DATA_CH0;
	endsequence

	chk_div_hidden: assert property (s_rd(scd_pkg::ADDR_DIVIDER_CH0) ##0
		i_ctrl[0].operation_enable |=> o_cpu_rdata == 8'h00)
		else $error("divider readable while enabled");
	chk_trig_reads: assert property (s_rd(scd_pkg::ADDR_TRIGGER_CH0)
		|=> o_cpu_rdata == 8'h00) else $error("trigger read not zero");
	chk_status_pad: assert property (s_rd(scd_pkg::ADDR_STATUS_CH0)
		|=> (o_cpu_rdata & 8'h9c) == 8'h00) else $error("status pad set");
	chk_busy_set: assert property (i_evt[0].comm_start |=> o_busy[0])
		else $error("busy not set on start");
	chk_busy_stop: assert property (i_ctrl[0].stop_trigger &&
		!i_evt[0].comm_start |=> !o_busy[0]) else $error("busy kept");
	chk_txv_gate: assert property (!i_ctrl[0].transmit_enable |->
		!o_tx_valid[0]) else $error("tx valid without enable");
	chk_tx_load: assert property (s_wr_data0 ##0
		i_ctrl[0].operation_enable && !i_evt[0].rx_store
		|=> o_tx_data[0] == $past(i_cpu.wdata)) else $error("tx not loaded");
	chk_tx_taken: assert property (o_tx_valid[0] && i_evt[0].tx_taken
		&& !i_cpu.wr && !i_evt[0].rx_store && !i_evt[0].rx_parity_bad
		|=> !o_tx_valid[0])
		else $error("full kept after move");
	chk_tick_idle: assert property (!i_ctrl[0].operation_enable [*2]
		|-> !o_xfer_tick[0]) else $error("tick while stopped");
endmodule

bind scd_serial_regs scd_regs_chk #(.NCH(NCH)) i_scd_regs_chk
(
	.i_core_clk(i_core_clk), .i_rst(i_rst), .i_cpu(i_cpu),
	.o_cpu_rdata(o_cpu_rdata), .i_ctrl(i_ctrl), .i_evt(i_evt),
	.i_serial_clock_pin(i_serial_clock_pin), .o_xfer_tick(o_xfer_tick),
	.o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data), .o_busy(o_busy)
);

// *** verification/scd_peer.sv ***
// Partner model: shift register events and serial clock pin
`timescale 1ns/100ps

module scd_peer
(
	// Clock
	input  wire logic               i_core_clk,
	// Towards the register block
	output scd_pkg::scd_shift_evt_t o_evt [2],
	output logic [1:0]              o_pin
);
	initial
	begin
		o_evt[0] = '0;
		o_evt[1] = '0;
		o_pin = 2'h0;
	end

	// Kinds: 0 start, 1 end, 2 suspend, 3 tx taken
	task pulse(input int ch, input int k);
		@(posedge i_core_clk);
		o_evt[ch][14:11] <= 4'h8 >> k;
		@(posedge i_core_clk);
		o_evt[ch][14:11] <= 4'h0;
	endtask

	task rx(input int ch, input logic [7:0] dat, input logic ns, input logic pb);
		@(posedge i_core_clk);
		o_evt[ch][10:0] <= {1'b1, dat, ns, pb};
		@(posedge i_core_clk);
		// Released data never holds its last value
		o_evt[ch][10:0] <= {1'b0, ~dat, 2'b00};
	endtask

	// pin clock: n pulses, each two cycles high and three low
	task sclk(input int ch, input int n);
		repeat (n)
		begin
			@(posedge i_core_clk);
			o_pin[ch] <= 1'b1;
			repeat (2) @(posedge i_core_clk);
			o_pin[ch] <= 1'b0;
			repeat (2) @(posedge i_core_clk);
		end
	endtask
endmodule

// *** verification/tb_top.sv ***
// Testbench: register scenarios of the two serial channels
`timescale 1ns/100ps

module tb_top;
	logic                    clk = 1'b0;
	logic                    rst = 1'b1;
	scd_pkg::scd_cpu_req_t   cpu = '0;
	scd_pkg::scd_chan_ctrl_t ctrl [2];
	scd_pkg::scd_shift_evt_t evt [2];
	logic [1:0]              pin;
	logic [1:0]              tick;
	logic [1:0]              txv;
	logic [1:0]              busy;
	logic [7:0]              txd [2];
	logic [7:0]              rdata;
	logic [7:0]              v;
	logic [7:0]              d;
	logic [7:0]              m;
	logic [7:0]              q [$];
	int                      num_errors = 0;
	int                      n_tests = 0;
	int                      seed = 15651;
	int                      cyc = 0;
	int                      t_last = 0;
	int                      gap = 0;
	int                      nt = 0;
	int                      tc = 0;
	localparam logic [19:0]  ADR [8] = '{20'hf0100, 20'hf0102, 20'hf0108,
		20'hf010a, 20'hfff10, 20'hfff11, 20'hfff12, 20'hfff13};

	always #20 clk = ~clk;

	scd_serial_regs i_scd_serial_regs
	(
		.i_core_clk(clk), .i_rst(rst), .i_cpu(cpu), .o_cpu_rdata(rdata),
		.i_ctrl(ctrl), .i_evt(evt), .i_serial_clock_pin(pin),
		.o_xfer_tick(tick), .o_tx_valid(txv), .o_tx_data(txd), .o_busy(busy)
	);
	scd_peer i_scd_peer (.i_core_clk(clk), .o_evt(evt), .o_pin(pin));

	always @(posedge clk)
	begin
		cyc++;
		if (tick[tc] === 1'b1)
		begin
			gap = cyc - t_last;
			t_last = cyc;
			nt++;
		end
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [19:0] a, input logic [7:0] dd);
		@(posedge clk);
		cpu <= '{1'b0, 1'b1, a, dd};
		@(posedge clk);
		cpu.wr <= 1'b0;
		@(negedge clk);
	endtask
	task rdc(input logic [19:0] a, input logic [7:0] exp);
		@(posedge clk);
		cpu <= '{1'b1, 1'b0, a, 8'h00};
		@(posedge clk);
		cpu.rd <= 1'b0;
		@(negedge clk);
		chk(rdata, exp);
	endtask
	task trg(input logic start);
		@(posedge clk);
		ctrl[0].stop_trigger <= !start;
		ctrl[0].start_trigger <= start;
		@(posedge clk);
		ctrl[0].stop_trigger <= 1'b0;
		ctrl[0].start_trigger <= 1'b0;
	endtask
	task end_of_test;
		$display("checks %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial
	begin
		#(40 * 5000);
		num_errors++;
		end_of_test;
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial
	begin
		ctrl[0] = '0;
		ctrl[1] = '0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		foreach (ADR[i])
			rdc(ADR[i], 8'h00);
		$display("test reset done");
		// not a UART here, so small divisors are fair
		d = 8'($random(seed)) & 8'h0f;
		wr(ADR[5], d);
		rdc(ADR[5], d);
		@(posedge clk);
		ctrl[0].operation_enable <= 1'b1;
		repeat (40) @(posedge clk);
		chk(8'(gap), 8'(2 * (d[7:1] + 1)));
		rdc(ADR[5], 8'h00);
		wr(ADR[5], 8'hfe);
		@(posedge clk);
		ctrl[0].operation_enable <= 1'b0;
		rdc(ADR[5], d);
		tc = 1;
		@(posedge clk);
		ctrl[1].external_clock_select <= 1'b1;
		ctrl[1].operation_enable <= 1'b1;
		nt = 0;
		i_scd_peer.sclk(1, 5);
		chk(8'(nt), 8'h05);
		$display("test divider done");
		@(posedge clk);
		ctrl[1] <= '0;
		// data writes only while the channel runs
		ctrl[0] <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
		d = 8'($random(seed));
		wr(ADR[4], d);
		chk(txd[0], d);
		chk(8'(txv), 8'h01);
		rdc(ADR[0], 8'h20);
		wr(ADR[4], ~d);
		chk(txd[0], ~d);
		rdc(ADR[0], 8'h21);
		i_scd_peer.pulse(0, 3);
		rdc(ADR[0], 8'h01);
		chk(8'(txv), 8'h00);
		wr(ADR[2], 8'h01);
		rdc(ADR[2], 8'h00);
		rdc(ADR[0], 8'h00);
		i_scd_peer.pulse(0, 0);
		rdc(ADR[0], 8'h40);
		chk(8'(busy), 8'h01);
		i_scd_peer.pulse(0, 1);
		rdc(ADR[0], 8'h00);
		i_scd_peer.pulse(0, 0);
		i_scd_peer.pulse(0, 2);
		rdc(ADR[0], 8'h00);
		i_scd_peer.pulse(0, 0);
		wr(ADR[4], d);
		trg(1'b0);
		rdc(ADR[0], 8'h00);
		wr(ADR[4], d);
		trg(1'b1);
		rdc(ADR[0], 8'h00);
		$display("test transmit done");
		@(posedge clk);
		ctrl[0] <= '0;
		ctrl[1] <= '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
		for (int k = 0; k < 4; k++)
		begin
			d = 8'($random(seed));
			q.push_back(d);
			i_scd_peer.rx(1, d, k[1], k[0]);
			m = 8'h20 | 8'(k << 1);
			rdc(ADR[1], m);
			rdc(ADR[6], q.pop_front());
			rdc(ADR[1], m & 8'h06);
			wr(ADR[3], m & 8'h06);
			rdc(ADR[1], 8'h00);
		end
		$display("test receive done");
		end_of_test;
	end
endmodule
